/* File: inq_fmt.sv */
// inquiry decoder and element status formatter with wishbone registers
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "inq_fmt_cfg.svh"
// Overview of operation
// - descriptor is 32 bytes: id 4-7, type 14, health 15, capacity 16-23; here bytes 16-17 are zero and the 48-bit capacity fills 18-23.
// - element id is non-zero and sent most significant byte first.
// - element type is always 01h, storage element.
// - health codes not reported, within, at, beyond limit; D0h-FCh never.
// - depopulation reported as FEh running, FDh error, FFh done.
// - device may use only a subset of health codes.
// - capacity holds lost blocks; all ones means unspecified; here bytes 16-17 stay zero, so only the low 48 bits can be all ones.
// - inquiry block is six bytes, opcode 12h, page 2, length 3-4.
// - vpd clear and page zero returns standard data.
// - vpd clear with non-zero page ends in check condition, bad cdb.
// - vpd set returns the named vital product data page; here every known non-zero page is the all-zero generic image with its code in byte 1.
// - zero allocation length transfers no data.
// - transfer stops at smaller of available and allocated bytes.
// - pending unit attention does not block inquiry and stays set.
// - inquiry runs at once and is never queued; here one arriving while busy is ignored.
// - content constant except revision after download and page 3.
// - data may be incomplete while media is unavailable.
// - byte 0 is qualifier zero, device type zero on every page.
// - character fields are ascii, others binary.
// - descriptors go out in ascending element id order.
module inq_fmt
    import inq_fmt_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // command block in, six bytes, byte 0 in bits 47:40
    input  wire logic        i_cdb_valid,
    input  wire logic [47:0] i_cdb,
    input  wire logic        i_unit_attention,
    // descriptor request and element source
    input  wire logic        i_desc_start,
    input  wire logic [3:0]  i_desc_count,
    input  wire logic [7:0]  i_health,
    input  wire logic [47:0] i_capacity,
    // data in stream
    output logic             o_din_valid,
    output logic      [7:0]  o_din_data,
    output logic             o_din_last,
    // completion
    output logic             o_status_valid,
    output logic      [7:0]  o_status,
    output logic      [3:0]  o_sense_key,
    output logic      [7:0]  o_sense_asc,
    output logic             o_unit_attention,
    output logic             o_busy
);
    fmt_state_type state;
    fmt_state_type next_state;
    logic [15:0] count;
    logic [15:0] limit;
    logic        pipe;
    logic        pipe_last;
    logic [1:0]  page;
    logic [31:0] revision;
    logic        media_ready;
    logic [31:0] elem_id;
    logic [3:0]  elems_left;
    logic        check;
    logic [7:0]  rom_data;
    logic [7:0]  desc_data;
    logic        pipe_desc;
    logic [7:0]  pipe_idx;
    logic [7:0]  page_id;

    // pages served here; anything else ends in check condition
    function automatic logic vpd_page_known(input logic [7:0] code);
        case (code)
            8'h00, 8'h03, 8'h80, 8'h83, 8'h86, 8'h87: vpd_page_known = 1'b1;
            default: vpd_page_known = 1'b0;
        endcase
    endfunction

    // command decode; vendor_unique_bits and flag/link are ignored
    wire        is_inq    = i_cdb[47:40] == `OPC_INQUIRY;
    wire        vpd_sel   = i_cdb[32];
    wire [7:0]  page_code = i_cdb[31:24];
    wire [15:0] alloc     = i_cdb[23:8];
    wire        bad_page  = !vpd_sel && page_code != 8'h00;
    wire        vpd_known = vpd_page_known(page_code);
    // standard data shrinks to its first 36 bytes while media is missing
    wire [15:0] avail     = !vpd_sel ? (media_ready ?
                            {8'h00, `STD_INQ_LEN} : 16'h0024) :
                            (page_code == 8'h00 ?
                            {8'h00, `VPD_LIST_LEN} :
                            {8'h00, `VPD_GEN_LEN});
    wire [15:0] xfer      = (alloc < avail) ? alloc : avail;
    wire        start_inq = i_cdb_valid && is_inq && state == ST_IDLE;
    wire        wb_hit    = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire        wb_write  = wb_hit && i_wb_we;
    wire        in_data   = state == ST_INQ || state == ST_DESC;
    wire        at_end    = count + 16'h0001 == limit;
    wire [4:0]  desc_idx  = count[4:0];

    // page contents; page 3 comes from the generic image as it may vary
    inq_rom u_rom (
        .i_clock    (i_clock),
        .i_page     (page),
        .i_addr     (count[7:0]),
        .i_revision (revision),
        .o_data     (rom_data)
    );

    // one descriptor generator reused per element
    elem_desc u_desc (
        .i_clock    (i_clock),
        .i_index    (desc_idx),
        .i_elem_id  (elem_id),
        .i_health   (i_health),
        .i_capacity (i_capacity),
        .o_data     (desc_data)
    );

    // next state: in idle an inquiry wins over a descriptor request and is taken directly; while busy it is ignored
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_inq)
                    next_state = (bad_page || xfer == 16'h0000 ||
                                  (vpd_sel && !vpd_known)) ?
                                 ST_STAT : ST_INQ;
                else if (i_desc_start && i_desc_count != 4'h0)
                    next_state = ST_DESC;
            end
            ST_INQ:  if (at_end) next_state = ST_STAT;
            ST_DESC: if (at_end && elems_left == 4'h1) next_state = ST_STAT;
            ST_STAT: next_state = ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // sequencing state and byte counter
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state      <= ST_IDLE;
            count      <= 16'h0000;
            limit      <= 16'h0000;
            page       <= 2'd0;
            page_id    <= 8'h00;
            check      <= 1'b0;
            elem_id    <= 32'h0000_0000;
            elems_left <= 4'h0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE) begin
                count <= 16'h0000;
                if (start_inq) begin
                    limit <= xfer;
                    check <= bad_page || (vpd_sel && !vpd_known);
                    page  <= !vpd_sel ? 2'd0 :
                             (page_code == 8'h00 ? 2'd1 : 2'd2);
                    page_id <= page_code;
                end else if (i_desc_start) begin
                    limit      <= {10'h000, `DESC_BYTES};
                    check      <= 1'b0;
                    elem_id    <= 32'h0000_0001;
                    elems_left <= i_desc_count;
                end
            end else if (in_data) begin
                count <= at_end ? 16'h0000 : count + 16'h0001;
                if (state == ST_DESC && at_end) begin
                    elem_id    <= elem_id + 32'h0000_0001;
                    elems_left <= elems_left - 4'h1;
                end
            end
        end
    end

    // data out lags the byte index by one cycle through registered memories
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pipe      <= 1'b0;
            pipe_last <= 1'b0;
            pipe_desc <= 1'b0;
            pipe_idx  <= 8'h00;
        end else begin
            pipe      <= in_data;
            pipe_desc <= state == ST_DESC; // source while last byte drains
            pipe_idx  <= count[7:0];
            pipe_last <= in_data && at_end &&
                         (state == ST_INQ || elems_left == 4'h1);
        end
    end

    // source follows the registered flag so a frame's last byte is not
    // taken from the other image; vpd pages echo their code in byte 1
    assign o_din_valid = pipe;
    assign o_din_last  = pipe_last;
    assign o_din_data  = pipe_desc ? desc_data :
                         (page != 2'd0 && pipe_idx == 8'h01) ? page_id :
                         rom_data;

    // completion status and sense
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_status_valid <= 1'b0;
            o_status       <= `STATUS_GOOD;
            o_sense_key    <= 4'h0;
            o_sense_asc    <= 8'h00;
        end else begin
            o_status_valid <= state == ST_STAT;
            if (state == ST_STAT) begin
                o_status    <= check ? `STATUS_CHECK : `STATUS_GOOD;
                o_sense_key <= check ? `SENSE_ILLEGAL_REQ : 4'h0;
                o_sense_asc <= check ? `ASC_INVALID_CDB : 8'h00;
            end
        end
    end

    // inquiry never clears a pending unit attention
    assign o_unit_attention = i_unit_attention;
    assign o_busy           = state != ST_IDLE;

    // registers: ctrl bit0 media ready, revision updates after download
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            media_ready <= 1'b1;
            revision    <= `VENDOR_TAG;
            o_wb_ack    <= 1'b0;
            o_wb_dat    <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_hit;
            if (wb_write && i_wb_adr == `REG_CTRL && i_wb_sel[0])
                media_ready <= i_wb_dat[0];
            if (wb_write && i_wb_adr == `REG_REVISION)
                revision <= i_wb_dat;
            if (wb_hit && !i_wb_we) begin
                case (i_wb_adr)
                    `REG_CTRL:     o_wb_dat <= {31'h0, media_ready};
                    `REG_STATUS:   o_wb_dat <= {27'h0, state};
                    `REG_REVISION: o_wb_dat <= revision;
                    default:       o_wb_dat <= 32'h0000_0000;
                endcase
            end
        end
    end

    // assertions; data lags the byte index by one cycle, so index k
    // shows byte k-1 of the same descriptor on the output
    sequence last_byte_s;
        o_din_valid && o_din_last;
    endsequence
    sequence status_pulse_s;
        o_status_valid ##1 !o_status_valid;
    endsequence

    // descriptor layout and field contents
    no_rsv_health_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && desc_idx == 5'd16)
        |-> !(o_din_data >= `HEALTH_RSV_LO && o_din_data <= `HEALTH_RSV_HI))
        else $error("reserved health code sent");
    health_pass_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && desc_idx == 5'd16 &&
        $past(i_health) < `HEALTH_RSV_LO) |-> o_din_data == $past(i_health))
        else $error("health code altered");
    depop_pass_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && desc_idx == 5'd16 &&
        $past(i_health) >= `HEALTH_DEPOP_ERR)
        |-> o_din_data == $past(i_health))
        else $error("depopulation code altered");
    type_byte_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && desc_idx == 5'd15)
        |-> o_din_data == `ELEM_TYPE_STORAGE)
        else $error("element type wrong");
    cap_byte_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && desc_idx == 5'd19)
        |-> o_din_data == $past(i_capacity[47:40]))
        else $error("capacity byte wrong");
    rsv_zero_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC &&
        ((desc_idx >= 5'd1 && desc_idx <= 5'd4) || desc_idx >= 5'd25))
        |-> o_din_data == 8'h00)
        else $error("reserved descriptor byte not zero");
    desc_len_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) state == ST_DESC
        |-> limit == {10'h000, `DESC_BYTES})
        else $error("descriptor length not 32 bytes");
    id_nonzero_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) state == ST_DESC |-> elem_id != 32'h0)
        else $error("element id zero");
    id_first_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_IDLE && next_state == ST_DESC)
        |=> elem_id == 32'h0000_0001)
        else $error("first element id not one");
    id_lsb_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && desc_idx == 5'd8)
        |-> o_din_data == elem_id[7:0])
        else $error("element id byte order wrong");
    id_ascend_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (state == ST_DESC && at_end &&
        elems_left != 4'h1) |=> elem_id == $past(elem_id) + 32'h1)
        else $error("ids not ascending");

    // inquiry decode and transfer length
    zero_alloc_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (start_inq && alloc == 16'h0000)
        |=> state == ST_STAT ##1 !o_din_valid)
        else $error("data sent for zero allocation");
    std_page_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (start_inq && !vpd_sel && !bad_page &&
        alloc != 16'h0000) |=> state == ST_INQ && page == 2'd0)
        else $error("standard data not selected");
    vpd_page_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (start_inq && vpd_sel && vpd_known &&
        alloc != 16'h0000) |=> state == ST_INQ && page != 2'd0)
        else $error("vital product page not selected");
    bad_page_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (start_inq && bad_page)
        |-> ##2 o_status_valid && o_status == `STATUS_CHECK)
        else $error("missing check condition");
    sense_code_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (o_status_valid &&
        o_status == `STATUS_CHECK) |-> (o_sense_key == `SENSE_ILLEGAL_REQ &&
        o_sense_asc == `ASC_INVALID_CDB))
        else $error("wrong sense for check condition");
    inq_now_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) start_inq |=> state != ST_IDLE)
        else $error("inquiry not taken at once");
    byte_cap_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) in_data |-> count < limit)
        else $error("transfer past limit");
    byte_zero_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (o_din_valid && !pipe_desc &&
        pipe_idx == 8'h00) |-> o_din_data == 8'h00)
        else $error("byte 0 not qualifier 0, type 0");
    last_valid_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) o_din_last |-> o_din_valid)
        else $error("last flag without data");
    status_after_a: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) last_byte_s |=> status_pulse_s)
        else $error("status does not follow last byte");
endmodule

/* File: inq_fmt_cfg.svh */
// constants for the inquiry and element status formatter
`ifndef INQ_FMT_CFG_SVH
`define INQ_FMT_CFG_SVH
`define OPC_INQUIRY       8'h12
`define SENSE_ILLEGAL_REQ 4'h5
`define ASC_INVALID_CDB   8'h24
`define STD_INQ_LEN       8'hA4
`define VPD_LIST_LEN      8'h16
`define VPD_GEN_LEN       8'h08
`define DESC_BYTES        6'h20
`define ELEM_TYPE_STORAGE 8'h01
`define HEALTH_NOT_REP    8'h00
`define HEALTH_AT_LIMIT   8'h64
`define HEALTH_OUT_LO     8'h65
`define HEALTH_OUT_HI     8'hCF
`define HEALTH_RSV_LO     8'hD0
`define HEALTH_RSV_HI     8'hFC
`define HEALTH_DEPOP_ERR  8'hFD
`define HEALTH_DEPOP_RUN  8'hFE
`define HEALTH_DEPOP_OK   8'hFF
`define CAP_UNSPEC        48'hFFFF_FFFF_FFFF
`define STATUS_GOOD       8'h00
`define STATUS_CHECK      8'h02
// wishbone register offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_REVISION      4'h8
`define VENDOR_TAG        32'h5A5A_0001
`endif

/* File: inq_fmt_pkg.sv */
// types shared by the formatter modules
package inq_fmt_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_INQ   = 5'b00010,
        ST_DESC  = 5'b00100,
        ST_STAT  = 5'b01000,
        ST_DONE  = 5'b10000
    } fmt_state_type;
endpackage

/* File: inq_rom.sv */
// registered byte memory holding inquiry page contents
`timescale 1ns/1ps
`include "inq_fmt_cfg.svh"
module inq_rom (
    // clock
    input  wire logic       i_clock,
    // read port
    input  wire logic [1:0] i_page,
    input  wire logic [7:0] i_addr,
    input  wire logic [31:0] i_revision,
    output logic      [7:0] o_data
);
    logic [7:0] next_data;

    // page 0 standard data, 1 page list, 2 generic vpd
    // byte 0 is left zero on every page: qualifier 0, type 0
    always_comb begin
        next_data = 8'h00;
        if (i_page == 2'd0) begin
            case (i_addr)
                8'd2:    next_data = 8'h07;
                8'd3:    next_data = 8'h12;
                8'd4:    next_data = `STD_INQ_LEN - 8'h05;
                8'd5:    next_data = 8'h01;
                8'd6:    next_data = 8'h10;
                8'd7:    next_data = 8'h02;
                8'd32:   next_data = i_revision[31:24];
                8'd33:   next_data = i_revision[23:16];
                8'd34:   next_data = i_revision[15:8];
                8'd35:   next_data = i_revision[7:0];
                default: begin
                    // character fields hold ascii blanks or letters
                    if (i_addr >= 8'd8 && i_addr <= 8'd43)
                        next_data = (i_addr < 8'd10) ? 8'h56 : 8'h20;
                end
            endcase
        end else if (i_page == 2'd1) begin
            case (i_addr)
                8'd3:    next_data = 8'h12;
                8'd5:    next_data = 8'h03;
                8'd6:    next_data = 8'h80;
                8'd7:    next_data = 8'h83;
                8'd8:    next_data = 8'h86;
                8'd9:    next_data = 8'h87;
                default: next_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        o_data <= next_data;
    end
endmodule

/* File: elem_desc.sv */
// builds one 32 byte physical element status descriptor byte by byte
`timescale 1ns/1ps
`include "inq_fmt_cfg.svh"
module elem_desc (
    input  wire logic        i_clock,
    input  wire logic [4:0]  i_index,
    input  wire logic [31:0] i_elem_id,
    input  wire logic [7:0]  i_health,
    input  wire logic [47:0] i_capacity,
    output logic      [7:0]  o_data
);
    logic [7:0] next_data;
    logic [7:0] health_ok;

    // only a subset of codes is needed; reserved ones go out as 00h
    assign health_ok = (i_health >= `HEALTH_RSV_LO &&
                        i_health <= `HEALTH_RSV_HI) ?
                       `HEALTH_NOT_REP : i_health;

    always_comb begin
        case (i_index)
            5'd4:    next_data = i_elem_id[31:24];
            5'd5:    next_data = i_elem_id[23:16];
            5'd6:    next_data = i_elem_id[15:8];
            5'd7:    next_data = i_elem_id[7:0];
            5'd14:   next_data = `ELEM_TYPE_STORAGE;
            5'd15:   next_data = health_ok;
            5'd16:   next_data = 8'h00;
            5'd17:   next_data = 8'h00;
            5'd18:   next_data = i_capacity[47:40];
            5'd19:   next_data = i_capacity[39:32];
            5'd20:   next_data = i_capacity[31:24];
            5'd21:   next_data = i_capacity[23:16];
            5'd22:   next_data = i_capacity[15:8];
            5'd23:   next_data = i_capacity[7:0];
            default: next_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock) begin
        o_data <= next_data;
    end
endmodule

/* File: inq_fmt_host.sv */
// initiator model that issues six byte inquiry command blocks
`timescale 1ns/1ps
module inq_fmt_host (
    // request from the bench
    input  wire logic        i_clock,
    input  wire logic        i_go,
    input  wire logic        i_vpd_sel,
    input  wire logic [7:0]  i_page,
    input  wire logic [15:0] i_alloc,
    // command block toward the target
    output logic             o_cdb_valid,
    output logic      [47:0] o_cdb
);
    // idle until the bench asks for a command
    initial begin
        o_cdb_valid = 1'b0;
        o_cdb       = 48'h0000_0000_0000;
    end
    // reserved bits carry noise so the target has to ignore them
    always @(posedge i_clock) begin
        o_cdb_valid <= i_go;
        if (i_go) begin
            o_cdb <= {8'h12, 7'($urandom), i_vpd_sel, i_page, i_alloc,
                      2'b00, 4'($urandom), 2'b00};
        end else if (o_cdb_valid) begin
            // stale block is inverted so nothing can reuse the old value
            o_cdb <= ~o_cdb;
        end
    end
endmodule

/* File: inq_fmt_tb_top.sv */
// self-checking bench for the inquiry and element status formatter
`timescale 1ns/1ps
`include "inq_fmt_cfg.svh"
module inq_fmt_tb_top;
    logic        clk, rst, cyc, stb, we, go, vs, ua, dstart;
    logic [3:0]  adr, sel, dcnt;
    logic [31:0] wdat, rdat;
    logic [7:0]  pg, hl;
    logic [15:0] al;
    logic [47:0] cap, cdb;
    logic        cdb_v, ack, dv, dlast, stv, uao, busy;
    logic [7:0]  dd, st, asc;
    logic [3:0]  key;
    logic [9:0]  dq[$];
    logic [19:0] sq[$];
    logic [31:0] rq[$];
    int          error_cnt, checks, i;
    logic [7:0]  htab[10] = '{8'h00, 8'h01, 8'h63, 8'h64, 8'h65, 8'hCF,
                             8'hD0, 8'hFD, 8'hFE, 8'hFF};

    inq_fmt u_inq_fmt (.i_clock(clk), .i_sys_rst(rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_cdb_valid(cdb_v), .i_cdb(cdb), .i_unit_attention(ua),
        .i_desc_start(dstart), .i_desc_count(dcnt), .i_health(hl),
        .i_capacity(cap), .o_din_valid(dv), .o_din_data(dd),
        .o_din_last(dlast), .o_status_valid(stv), .o_status(st),
        .o_sense_key(key), .o_sense_asc(asc), .o_unit_attention(uao),
        .o_busy(busy));
    inq_fmt_host u_inq_fmt_host (.i_clock(clk), .i_go(go), .i_vpd_sel(vs),
        .i_page(pg), .i_alloc(al), .o_cdb_valid(cdb_v), .o_cdb(cdb));

    // free running clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // watcher: every result on the ports takes the oldest note
    always @(posedge clk) begin
        if (dv === 1'b1) begin
            if (dq.size() == 0) chk("din_extra", 0, 1);
            else begin
                chk("din_last", dq[0][8], dlast);
                if (dq[0][9]) chk("din_data", dq[0][7:0], dd);
                void'(dq.pop_front());
            end
        end
        if (stv === 1'b1 && sq.size() == 0) chk("status_extra", 0, 1);
        else if (stv === 1'b1) begin
            chk("status", sq[0][19:12], st);
            if (sq[0][19:12] == `STATUS_CHECK) begin
                chk("sense", sq[0][11:0], {key, asc});
            end
            void'(sq.pop_front());
        end
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
            chk("wb_read", rq.pop_front(), rdat);
        end
    end

    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        chk("wb_ack", 1, ack);
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask

    task rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    // waits out one command, bounded in case the block hangs
    task wait_idle(input string nm);
        int n;
        repeat (3) @(posedge clk);
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("busy", 0, busy);
        repeat (2) @(posedge clk);
        chk("bytes_left", 0, dq.size());
        chk("status_left", 0, sq.size());
        $display("test %s done", nm);
    endtask

    task inq(input logic v, input logic [7:0] p, input logic [15:0] a,
             input int avail, input logic bad, input string nm);
        int n, k;
        n = bad ? 0 : ((a < avail) ? a : avail);
        for (k = 0; k < n; k++) begin
            dq.push_back({k < 2, k == n - 1, (k == 1 && v) ? p : 8'h00});
        end
        sq.push_back(bad ? {`STATUS_CHECK, `SENSE_ILLEGAL_REQ,
                            `ASC_INVALID_CDB} : {`STATUS_GOOD, 12'h000});
        go <= 1'b1; vs <= v; pg <= p; al <= a;
        @(posedge clk);
        go <= 1'b0;
        wait_idle(nm);
    endtask

    task desc(input logic [3:0] c, input logic [7:0] h,
              input logic [47:0] cp);
        int k, b;
        logic [7:0] he, e;
        he = (h >= `HEALTH_RSV_LO && h <= `HEALTH_RSV_HI) ? 8'h00 : h;
        for (k = 1; k <= c; k++) begin
            for (b = 0; b < 32; b++) begin
                e = (b >= 4 && b <= 7) ? 8'(k >> (8 * (7 - b))) :
                    (b == 14) ? `ELEM_TYPE_STORAGE : (b == 15) ? he :
                    (b >= 18 && b <= 23) ? cp[8 * (23 - b) +: 8] : 8'h00;
                dq.push_back({1'b1, k == c && b == 31, e});
            end
        end
        if (c != 4'h0) sq.push_back({`STATUS_GOOD, 12'h000});
        dcnt <= c; hl <= h; cap <= cp; dstart <= 1'b1;
        @(posedge clk);
        dstart <= 1'b0;
        wait_idle("descriptor");
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        test_done;
    end

    initial begin
        rst = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF;
        wdat = 0; go = 0; vs = 0; pg = 0; al = 0; ua = 0; dstart = 0;
        dcnt = 0; hl = 0; cap = 0; error_cnt = 0;
        checks = 0;
        void'($urandom(77618));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`REG_CTRL, 32'h0000_0001);
        rd(`REG_STATUS, 32'h0000_0001);
        rd(`REG_REVISION, `VENDOR_TAG);
        rd(4'hC, 32'h0000_0000);
        $display("test registers done");
        inq(1'b0, 8'h00, 16'h0005, `STD_INQ_LEN, 1'b0, "short");
        inq(1'b0, 8'h00, 16'h0000, `STD_INQ_LEN, 1'b0, "zero");
        inq(1'b0, 8'(1 + $urandom % 255), 16'h0010, 0, 1'b1, "bad");
        ua <= 1'b1;
        inq(1'b1, 8'h00, 16'h012C, `VPD_LIST_LEN, 1'b0, "ua");
        chk("unit_attention", 1, uao);
        ua <= 1'b0;
        inq(1'b1, 8'h03, 16'h012C, `VPD_GEN_LEN, 1'b0, "page3");
        inq(1'b0, 8'h00, 16'(164 + $urandom % 800), `STD_INQ_LEN, 1'b0,
            "long");
        wb(1'b1, `REG_CTRL, 32'h0000_0000);
        rd(`REG_CTRL, 32'h0000_0000);
        inq(1'b0, 8'h00, 16'h00C8, 36, 1'b0, "nomedia");
        wb(1'b1, `REG_CTRL, 32'h0000_0001);
        for (i = 0; i < 10; i++) begin
            desc(4'h1, htab[i], {16'h0000, 32'($urandom)});
        end
        desc(4'h2, 8'($urandom % 99 + 1), `CAP_UNSPEC);
        desc(4'h0, 8'h64, 48'h0000_0000_0001);
        test_done;
    end
endmodule
